// file: rtl/arc_readout.sv
// serial register port with result readout, checksums and integrity watch
`include "arc_regs.svh"

module arc_readout #(
	parameter logic [23:0] HIDDEN_WORD = 24'h000000,
	parameter logic [7:0]  CRC_POLY    = `ARC_CRC_POLY,
	parameter int          BUF_DEPTH   = 2
) (
	input  wire logic        MCLK_IN,
	input  wire logic        ARST_N_IN,
	input  wire logic        SCLK_IN,
	input  wire logic        CS_N_IN,
	input  wire logic        DIN_IN,
	output logic             DOUT_OUT,
	output logic             DOUT_OE_OUT,
	output logic             RDY_N_OUT,
	input  wire logic        CONV_VALID_IN,
	input  wire logic [23:0] CONV_DATA_IN,
	output logic             CONV_READY_OUT,
	input  wire logic        POLARITY_SELECT_IN,
	output logic [15:0]      PIN_IO_CONFIG_OUT,
	output logic             INTEGRITY_ERR_OUT
);
	// ****************************************************************
	// state
	// ****************************************************************
	arc_pkg::arc_state_t state;
	arc_pkg::arc_conv_t  result;
	arc_pkg::arc_conv_t  buf_word;
	logic [15:0] ifmode;
	logic [15:0] pin_io_config;
	logic        ready_n;
	logic        crc_err;
	logic        reg_err;
	logic        sclk_q;
	logic        reading_result;
	logic        is_read;
	logic [5:0]  addr;
	logic [5:0]  nbits;
	logic [5:0]  cnt;
	logic [2:0]  bitpos;
	logic [7:0]  crc;
	logic [7:0]  xacc;
	logic [7:0]  crc_rx;
	logic [23:0] in_shift;
	logic [31:0] out_shift;
	logic        buf_valid;

	// ****************************************************************
	// checksum steps
	// ****************************************************************
	function automatic logic [7:0] crc_step(input logic [7:0] c,
	                                        input logic b);
		crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
	endfunction

	function automatic logic [7:0] xor_step(input logic [7:0] a,
	                                        input logic [2:0] p,
	                                        input logic b);
		xor_step = a ^ ({7'h00, b} << (3'h7 - p));
	endfunction

	// ****************************************************************
	// decode
	// ****************************************************************
	// serial clock edges; pins are already in this clock domain
	wire sclk_rise = SCLK_IN && !sclk_q;
	wire sclk_fall = !SCLK_IN && sclk_q;
	wire frame     = !CS_N_IN;

	// mode fields
	wire [1:0] csum_sel = ifmode[`ARC_IFM_CSUM_HI:`ARC_IFM_CSUM_LO];
	wire       watch    = ifmode[`ARC_IFM_WATCH];
	wire       append   = ifmode[`ARC_IFM_APPEND];
	wire       short_ws = ifmode[`ARC_IFM_SHORT];
	wire       csum_on  = (csum_sel != `ARC_CSUM_OFF);
	// reads use xor only for code 01; code 11 falls back to the crc
	wire       rd_xor   = (csum_sel == `ARC_CSUM_XOR);

	// command byte completes on this rising edge
	wire [7:0] cmd_byte  = {in_shift[6:0], DIN_IN};
	wire       cmd_done  = frame && sclk_rise && (state == arc_pkg::ST_CMD)
	                       && (cnt == `ARC_LEN_BYTE - 6'h01);
	wire       cmd_ok    = !cmd_byte[`ARC_CMD_WEN_N];
	wire       cmd_rd    = cmd_byte[`ARC_CMD_READ];
	wire [5:0] cmd_addr  = cmd_byte[`ARC_CMD_ADDR_HI:0];
	wire       cmd_rd_result = cmd_done && cmd_ok && cmd_rd
	                           && (cmd_addr == `ARC_ADDR_RESULT);

	// status byte; spare bits read zero
	wire [7:0] status = {ready_n, crc_err, reg_err, 5'h00};

	// checksum register view
	wire [23:0] reg_checksum = watch ?
		({8'h00, pin_io_config} ^ HIDDEN_WORD) : 24'h000000;

	// result aligned to the top of the shifter, status byte after it when append is set
	wire [31:0] result_frame = result.short_word ?
		(append ? {result.value[23:8], status, 8'h00}
		        : {result.value[23:8], 16'h0000})
		: (append ? {result.value, status}
		          : {result.value, 8'h00});
	wire [5:0] result_len = (result.short_word ? `ARC_LEN_HALF : `ARC_LEN_WORD)
	                        + (append ? `ARC_LEN_BYTE : 6'h00);

	// read data and length for the addressed register
	logic [31:0] rd_frame;
	logic [5:0]  rd_len;
	always_comb begin
		rd_frame = 32'h00000000;
		rd_len   = `ARC_LEN_BYTE;
		case (cmd_addr)
			`ARC_ADDR_STATUS: begin
				rd_frame = {status, 24'h000000};
			end
			`ARC_ADDR_IFMODE: begin
				rd_frame = {ifmode, 16'h0000};
				rd_len   = `ARC_LEN_HALF;
			end
			`ARC_ADDR_CHECKSUM: begin
				rd_frame = {reg_checksum, 8'h00};
				rd_len   = `ARC_LEN_WORD;
			end
			`ARC_ADDR_RESULT: begin
				rd_frame = result_frame;
				rd_len   = result_len;
			end
			`ARC_ADDR_PINIO: begin
				rd_frame = {pin_io_config, 16'h0000};
				rd_len   = `ARC_LEN_HALF;
			end
			default: begin
				rd_frame = 32'h00000000;
			end
		endcase
	end

	// write length; checksum and result writes take an ignored word, status and unmapped registers one ignored byte
	wire [5:0] wr_len = (cmd_addr == `ARC_ADDR_CHECKSUM) ? `ARC_LEN_WORD :
	                    (cmd_addr == `ARC_ADDR_IFMODE ||
	                     cmd_addr == `ARC_ADDR_PINIO) ? `ARC_LEN_HALF :
	                    (cmd_addr == `ARC_ADDR_RESULT) ? `ARC_LEN_WORD :
	                    `ARC_LEN_BYTE;

	// bit moving this edge and running checksums including it
	wire        data_bit  = is_read ? out_shift[31] : DIN_IN;
	wire [7:0]  crc_next  = crc_step(crc, data_bit);
	wire [7:0]  xacc_next = xor_step(xacc, bitpos, data_bit);
	wire [7:0]  rd_csum   = rd_xor ? xacc_next : crc_next;
	wire        rd_edge   = sclk_fall && is_read;
	wire        wr_edge   = sclk_rise && !is_read;
	wire        last_data = (state == arc_pkg::ST_DATA)
	                        && (cnt == nbits - 6'h01);

	// write commit points: after data if unprotected, after checksum if not
	wire [23:0] wr_word   = {in_shift[22:0], DIN_IN};
	wire        commit_plain = frame && wr_edge && last_data && !csum_on;
	wire        csum_last = frame && wr_edge && (state == arc_pkg::ST_CSUM)
	                        && (cnt == `ARC_LEN_BYTE - 6'h01);
	wire        csum_good = ({crc_rx[6:0], DIN_IN} == crc);
	wire        commit    = commit_plain || (csum_last && csum_good);
	wire [23:0] commit_word = commit_plain ? wr_word : in_shift;
	wire        bad_csum  = csum_last && !csum_good;

	// register write effects
	wire        wr_ifmode = commit && (addr == `ARC_ADDR_IFMODE);
	wire        wr_pinio  = commit && (addr == `ARC_ADDR_PINIO);
	wire [15:0] new_pinio = commit_word[15:0] & `ARC_PIN_MASK;
	wire        pin_change = wr_pinio && (new_pinio != pin_io_config);
	wire        status_rd  = cmd_done && cmd_ok && cmd_rd
	                         && (cmd_addr == `ARC_ADDR_STATUS);

	// ****************************************************************
	// conversion path
	// ****************************************************************
	// the word length is caught when a conversion completes, so a mode
	// write never disturbs a result already on its way
	wire arc_pkg::arc_conv_t conv_in = '{short_word: short_ws,
	                                     value:      CONV_DATA_IN};
	// hold the buffer while the result is being shifted out
	wire drain = buf_valid && !reading_result && !cmd_rd_result;

	arc_pair_buffer #(
		.WIDTH ($bits(arc_pkg::arc_conv_t)),
		.DEPTH (BUF_DEPTH)
	) u_buffer (
		.clk_in        (MCLK_IN),
		.rst_n_in      (ARST_N_IN),
		.in_valid_in   (CONV_VALID_IN),
		.in_data_in    (conv_in),
		.in_ready_out  (CONV_READY_OUT),
		.out_valid_out (buf_valid),
		.out_data_out  (buf_word),
		.out_ready_in  (!reading_result && !cmd_rd_result)
	);

	// ****************************************************************
	// result and ready
	// ****************************************************************
	// loading clears ready; a read sets it, and the two never meet in one
	// cycle because loading is held off on the decode edge
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			result  <= '{short_word: 1'b0, value: `ARC_RESULT_RESET};
			ready_n <= 1'b1;
		end else if (drain) begin
			result.short_word <= buf_word.short_word;
			result.value      <= POLARITY_SELECT_IN ? buf_word.value
				: {~buf_word.value[`ARC_RESULT_MSB],
				   buf_word.value[`ARC_RESULT_MSB-1:0]};
			ready_n <= 1'b0;
		end else if (cmd_rd_result) begin
			ready_n <= 1'b1;
		end
	end

	// ****************************************************************
	// configuration registers and flags
	// ****************************************************************
	// a bad checksum or an error event wins over a clear in the same cycle
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ifmode        <= `ARC_IFM_RESET;
			pin_io_config <= `ARC_PIN_RESET;
			crc_err       <= 1'b0;
			reg_err       <= 1'b0;
		end else begin
			if (wr_ifmode) begin
				ifmode <= commit_word[15:0] & `ARC_IFM_MASK;
			end
			if (wr_pinio) begin
				pin_io_config <= new_pinio;
			end
			if (bad_csum) begin
				crc_err <= 1'b1;
			end else if (status_rd) begin
				crc_err <= 1'b0;
			end
			if (pin_change && watch) begin
				reg_err <= 1'b1;
			end else if (wr_ifmode && !commit_word[`ARC_IFM_WATCH]) begin
				reg_err <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// serial frame engine
	// ****************************************************************
	// bits enter on rising edges and leave on falling edges; raising the
	// chip select abandons the frame and any uncommitted write
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			state          <= arc_pkg::ST_CMD;
			sclk_q         <= 1'b1;
			is_read        <= 1'b0;
			reading_result <= 1'b0;
			addr           <= 6'h00;
			nbits          <= `ARC_LEN_BYTE;
			cnt            <= 6'h00;
			bitpos         <= 3'h0;
			crc            <= 8'h00;
			xacc           <= 8'h00;
			crc_rx         <= 8'h00;
			in_shift       <= 24'h000000;
			out_shift      <= 32'h00000000;
			DOUT_OUT       <= 1'b0;
		end else begin
			sclk_q <= SCLK_IN;
			if (!frame) begin
				state          <= arc_pkg::ST_CMD;
				is_read        <= 1'b0;
				reading_result <= 1'b0;
				cnt            <= 6'h00;
				bitpos         <= 3'h0;
				crc            <= 8'h00;
				xacc           <= 8'h00;
			end else begin
				unique case (state)
					arc_pkg::ST_CMD: begin
						if (sclk_rise) begin
							in_shift <= {in_shift[22:0], DIN_IN};
							crc      <= crc_step(crc, DIN_IN);
							xacc     <= xor_step(xacc, bitpos, DIN_IN);
							bitpos   <= bitpos + 3'h1;
							cnt      <= cnt + 6'h01;
						end
						if (cmd_done) begin
							cnt            <= 6'h00;
							addr           <= cmd_addr;
							is_read        <= cmd_rd;
							reading_result <= cmd_rd_result;
							out_shift      <= rd_frame;
							nbits          <= cmd_rd ? rd_len : wr_len;
							state          <= cmd_ok ? arc_pkg::ST_DATA
							                         : arc_pkg::ST_DONE;
						end
					end
					arc_pkg::ST_DATA: begin
						if (rd_edge || wr_edge) begin
							crc    <= crc_next;
							xacc   <= xacc_next;
							bitpos <= bitpos + 3'h1;
							cnt    <= cnt + 6'h01;
						end
						if (rd_edge) begin
							DOUT_OUT  <= out_shift[31];
							out_shift <= {out_shift[30:0], 1'b0};
						end
						if (wr_edge) begin
							in_shift <= wr_word;
						end
						if ((rd_edge || wr_edge) && last_data) begin
							cnt <= 6'h00;
							// checksum byte goes last, after every data bit
							state <= csum_on ? arc_pkg::ST_CSUM
							                 : arc_pkg::ST_DONE;
							if (is_read) begin
								out_shift <= {rd_csum, 24'h000000};
							end
						end
					end
					arc_pkg::ST_CSUM: begin
						if (rd_edge) begin
							DOUT_OUT  <= out_shift[31];
							out_shift <= {out_shift[30:0], 1'b0};
							cnt       <= cnt + 6'h01;
						end
						if (wr_edge) begin
							crc_rx <= {crc_rx[6:0], DIN_IN};
							cnt    <= cnt + 6'h01;
						end
						if ((rd_edge || wr_edge)
						    && cnt == `ARC_LEN_BYTE - 6'h01) begin
							state <= arc_pkg::ST_DONE;
						end
					end
					arc_pkg::ST_DONE: begin
						// result reads release the buffer once the last bit left
						reading_result <= 1'b0;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// pin drivers
	// ****************************************************************
	// data pin is driven for the whole frame; ready pin mirrors the flag
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			DOUT_OE_OUT       <= 1'b0;
			RDY_N_OUT         <= 1'b1;
			PIN_IO_CONFIG_OUT <= `ARC_PIN_RESET;
			INTEGRITY_ERR_OUT <= 1'b0;
		end else begin
			DOUT_OE_OUT       <= frame;
			RDY_N_OUT         <= ready_n;
			PIN_IO_CONFIG_OUT <= pin_io_config;
			INTEGRITY_ERR_OUT <= reg_err;
		end
	end
endmodule

// file: rtl/arc_regs.svh
// register offsets, field positions, reset values and counts of the readout block
`ifndef ARC_REGS_SVH
`define ARC_REGS_SVH

// ****************************************************************
// register offsets on the serial port
// ****************************************************************
`define ARC_ADDR_STATUS    6'h00
`define ARC_ADDR_IFMODE    6'h02
`define ARC_ADDR_CHECKSUM  6'h03
`define ARC_ADDR_RESULT    6'h04
`define ARC_ADDR_PINIO     6'h06

// ****************************************************************
// command byte fields
// ****************************************************************
`define ARC_CMD_WEN_N      7
`define ARC_CMD_READ       6
`define ARC_CMD_ADDR_HI    5

// ****************************************************************
// interface mode fields
// ****************************************************************
`define ARC_IFM_SHORT      0
`define ARC_IFM_CSUM_LO    2
`define ARC_IFM_CSUM_HI    3
`define ARC_IFM_WATCH      5
`define ARC_IFM_APPEND     6
`define ARC_IFM_MASK       16'h006d
`define ARC_IFM_RESET      16'h0000

// ****************************************************************
// checksum select codes
// ****************************************************************
`define ARC_CSUM_OFF       2'h0
`define ARC_CSUM_XOR       2'h1
`define ARC_CSUM_CRC       2'h2

// ****************************************************************
// status byte fields
// ****************************************************************
`define ARC_ST_READY_N     7
`define ARC_ST_CRC_ERR     6
`define ARC_ST_REG_ERR     5

// ****************************************************************
// pin configuration and result resets
// ****************************************************************
`define ARC_PIN_MASK       16'h7fff
`define ARC_PIN_RESET      16'h0800
`define ARC_RESULT_RESET   24'h000000
`define ARC_RESULT_MSB     23

// ****************************************************************
// transfer lengths in bits and crc polynomial
// ****************************************************************
`define ARC_LEN_BYTE       6'h08
`define ARC_LEN_HALF       6'h10
`define ARC_LEN_WORD       6'h18
`define ARC_CRC_POLY       8'h07

`endif

// file: rtl/arc_pkg.sv
// types shared by the readout and integrity check block
package arc_pkg;

	// one conversion word with the length it was completed at
	typedef struct packed {
		logic        short_word;
		logic [23:0] value;
	} arc_conv_t;

	// serial frame phases
	typedef enum logic [1:0] {
		ST_CMD  = 2'b00,
		ST_DATA = 2'b01,
		ST_CSUM = 2'b10,
		ST_DONE = 2'b11
	} arc_state_t;

endpackage

// file: rtl/arc_pair_buffer.sv
// small fifo with valid and ready on both sides, used for conversion words
module arc_pair_buffer #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 2
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	output logic                  out_valid_out,
	output logic      [WIDTH-1:0] out_data_out,
	input  wire logic             out_ready_in
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [CW-1:0]    count;
	logic [CW-1:0]    next_count;

	// handshakes and occupancy
	wire push = in_valid_in && in_ready_out;
	wire pop  = out_valid_out && out_ready_in;
	assign next_count = count + CW'(push) - CW'(pop);
	assign out_valid_out = (count != '0);
	assign out_data_out  = mem[rd_ptr];

	// storage has no reset; count guards every read of it
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

	// pointers wrap at depth; ready is registered so the source sees a flop
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr       <= '0;
			rd_ptr       <= '0;
			count        <= '0;
			in_ready_out <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
			end
			count        <= next_count;
			in_ready_out <= (next_count != CW'(DEPTH));
		end
	end
endmodule

// file: sim/arc_readout_assertions.sv
// concurrent checks on the readout block ports
module arc_readout_assertions (
	input wire logic        MCLK_IN,
	input wire logic        ARST_N_IN,
	input wire logic        CS_N_IN,
	input wire logic        DOUT_OE_OUT,
	input wire logic        RDY_N_OUT,
	input wire logic        CONV_VALID_IN,
	input wire logic        CONV_READY_OUT,
	input wire logic [15:0] PIN_IO_CONFIG_OUT,
	input wire logic        INTEGRITY_ERR_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	// ********
	// properties
	// ********
	// one clock domain, so clocking and disable are shared
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!ARST_N_IN);

	// pin bit 15 stays zero; register side effects only come out of a serial frame
	a_pin_reserved_zero: assert property (!PIN_IO_CONFIG_OUT[15])
		else $error("pin config bit 15 set");
	a_pin_frame_only: assert property (
		$changed(PIN_IO_CONFIG_OUT) |-> !$past(CS_N_IN))
		else $error("pin config changed outside a frame");
	a_err_frame_only: assert property (
		$changed(INTEGRITY_ERR_OUT) |-> !$past(CS_N_IN))
		else $error("integrity flag moved outside a frame");
	a_ready_high_read: assert property (
		$rose(RDY_N_OUT) |-> !$past(CS_N_IN, 2))
		else $error("ready released without a read");
	// cs high before and after the accept rules out a held buffer
	a_ready_on_load: assert property (
		CS_N_IN ##1 (CONV_VALID_IN && CONV_READY_OUT && CS_N_IN)
		##1 CS_N_IN [*2] |=> !RDY_N_OUT)
		else $error("ready not low three cycles after a word");
	a_ready_stays_low: assert property (
		!RDY_N_OUT && CS_N_IN && $past(CS_N_IN) |=> !RDY_N_OUT)
		else $error("ready released while idle");
	a_oe_follows_cs: assert property (
		DOUT_OE_OUT == !$past(CS_N_IN))
		else $error("output enable not one cycle after select");
	a_full_refuse: assert property (
		$fell(CONV_READY_OUT) |-> $past(CONV_VALID_IN))
		else $error("buffer refused without a new word");
endmodule

bind arc_readout arc_readout_assertions chk (
	.MCLK_IN(MCLK_IN), .ARST_N_IN(ARST_N_IN), .CS_N_IN(CS_N_IN),
	.DOUT_OE_OUT(DOUT_OE_OUT), .RDY_N_OUT(RDY_N_OUT),
	.CONV_VALID_IN(CONV_VALID_IN), .CONV_READY_OUT(CONV_READY_OUT),
	.PIN_IO_CONFIG_OUT(PIN_IO_CONFIG_OUT),
	.INTEGRITY_ERR_OUT(INTEGRITY_ERR_OUT));

// file: sim/arc_host_model.sv
// serial host that frames register reads and writes
`include "arc_regs.svh"
module arc_host_model (
	input  wire logic mclk_in,
	input  wire logic dout_in,
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      din_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ********
	// framing
	// ********
	// idle: clock high, not selected
	initial begin
		sclk_out = 1'b1;
		cs_n_out = 1'b1;
		din_out  = 1'b0;
	end

	// crc msb first, init zero, no final xor
	function automatic logic [7:0] crc8(input logic [47:0] v, input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = n - 1; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? `ARC_CRC_POLY : 8'h00);
		return c;
	endfunction

	function automatic logic [7:0] xsum(input logic [47:0] v, input int n);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < n; i += 8)
			s ^= v[i+:8];
		return s;
	endfunction

	// three low samples so dout has settled before the rise
	task automatic bit_cell(input logic b, output logic r);
		@(posedge mclk_in);
		sclk_out <= 1'b0;
		din_out  <= b;
		repeat (3) @(posedge mclk_in);
		@(negedge mclk_in);
		r = dout_in;
		@(posedge mclk_in);
		sclk_out <= 1'b1;
		@(posedge mclk_in);
	endtask

	// mode 0 none, 1 xor reads, 2 crc, 3 crc spoiled on a write
	task automatic xfer(input logic [7:0] cmd, input logic [31:0] wd,
		input int n, input int mode, output logic [31:0] rd,
		output logic [7:0] rs, output logic [7:0] es);
		logic [47:0] fr;
		logic [47:0] got;
		logic [47:0] v;
		logic        r;
		int          t;
		fr  = ({40'h0, cmd} << n) | {16'h0, wd};
		t   = 8 + n;
		got = 48'h0;
		if (mode != 0) begin
			t  = t + 8; // one checksum byte, sent last
			fr = fr << 8;
			if (!cmd[6])
				fr[7:0] = crc8(fr >> 8, t - 8) ^ {8{mode == 3}};
		end
		@(posedge mclk_in);
		cs_n_out <= 1'b0;
		repeat (2) @(posedge mclk_in);
		for (int i = t - 1; i >= 0; i--) begin
			bit_cell(fr[i], r);
			got = {got[46:0], r};
		end
		repeat (2) @(posedge mclk_in);
		cs_n_out <= 1'b1;
		repeat (3) @(posedge mclk_in);
		rs  = (mode != 0) ? got[7:0] : 8'h00;
		got = got >> ((mode != 0) ? 8 : 0);
		rd  = got[31:0] & ((32'h1 << n) - 32'h1);
		v   = ({40'h0, cmd} << n) | {16'h0, rd};
		es  = (mode == 1) ? xsum(v, n + 8) : crc8(v, n + 8);
	endtask
endmodule

// file: sim/tb.sv
// self-checking bench for the readout and integrity registers
`include "arc_regs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk, arst_n, sclk, cs_n, din, dout, dout_oe;
	logic        rdy_n, cv, cr, pol, err;
	logic [23:0] cd;
	logic [15:0] pin;
	logic [31:0] rd;
	logic [7:0]  rs, es;
	int          failures, n_checks;
	// released line is pulled high
	wire         dout_wire = dout_oe ? dout : 1'b1;

	// ********
	// harness
	// ********
	arc_readout #(.HIDDEN_WORD(24'h5a0000)) dut (
		.MCLK_IN(mclk), .ARST_N_IN(arst_n), .SCLK_IN(sclk),
		.CS_N_IN(cs_n), .DIN_IN(din), .DOUT_OUT(dout),
		.DOUT_OE_OUT(dout_oe), .RDY_N_OUT(rdy_n), .CONV_VALID_IN(cv),
		.CONV_DATA_IN(cd), .CONV_READY_OUT(cr), .POLARITY_SELECT_IN(pol),
		.PIN_IO_CONFIG_OUT(pin), .INTEGRITY_ERR_OUT(err));
	arc_host_model host (.mclk_in(mclk), .dout_in(dout_wire),
		.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din));

	// 10 MHz clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic complete_run();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic rd_reg(input logic [5:0] a, input int n, input int m,
		input logic [31:0] e);
		host.xfer({2'b01, a}, 32'h0, n, m, rd, rs, es);
		check(rd, e);
		if (m != 0)
			check({24'h0, rs}, {24'h0, es});
	endtask

	task automatic wr_reg(input logic [5:0] a, input logic [31:0] d,
		input int n, input int m);
		host.xfer({2'b00, a}, d, n, m, rd, rs, es);
	endtask

	// a gap cycle keeps valid from being driven twice in one step
	task automatic push(input logic [23:0] d);
		int k;
		@(posedge mclk);
		cv <= 1'b1;
		cd <= d;
		for (k = 0; k < 900; k++) begin
			@(posedge mclk);
			if (cr === 1'b1)
				break;
		end
		cv <= 1'b0;
		if (k == 900) begin
			failures++;
			complete_run();
		end
	endtask

	// ********
	// sequence
	// ********
	initial begin
		arst_n = 1'b0;
		cv = 1'b0;
		cd = 24'h0;
		pol = 1'b0;
		failures = 0;
		n_checks = 0;
		repeat (5) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		check({16'h0, pin}, 32'h0800);
		rd_reg(`ARC_ADDR_PINIO, 16, 0, 32'h0800);
		rd_reg(`ARC_ADDR_CHECKSUM, 24, 0, 32'h0);
		rd_reg(6'h3f, 8, 0, 32'h0);
		wr_reg(`ARC_ADDR_PINIO, 32'hffff, 16, 0);
		rd_reg(`ARC_ADDR_PINIO, 16, 0, 32'h7fff);
		wr_reg(`ARC_ADDR_CHECKSUM, 32'h123456, 24, 0);
		wr_reg(`ARC_ADDR_RESULT, 32'habcdef, 24, 0);
		rd_reg(`ARC_ADDR_RESULT, 24, 0, 32'h0);
		wr_reg(`ARC_ADDR_IFMODE, 32'h0020, 16, 0);
		rd_reg(`ARC_ADDR_CHECKSUM, 24, 0, 32'h5a7fff);
		wr_reg(`ARC_ADDR_PINIO, 32'h1234, 16, 0);
		check({31'h0, err}, 32'h1);
		rd_reg(`ARC_ADDR_STATUS, 8, 0, 32'ha0);
		wr_reg(`ARC_ADDR_IFMODE, 32'h0000, 16, 0);
		check({31'h0, err}, 32'h0);
		rd_reg(`ARC_ADDR_CHECKSUM, 24, 0, 32'h0);
		push(24'h123456);
		repeat (5) @(posedge mclk);
		check({31'h0, rdy_n}, 32'h0);
		rd_reg(`ARC_ADDR_RESULT, 24, 0, 32'h923456);
		check({31'h0, rdy_n}, 32'h1);
		rd_reg(`ARC_ADDR_RESULT, 24, 0, 32'h923456);
		pol <= 1'b1;
		push(24'h800001);
		repeat (5) @(posedge mclk);
		wr_reg(`ARC_ADDR_IFMODE, 32'h0001, 16, 0);
		rd_reg(`ARC_ADDR_RESULT, 24, 0, 32'h800001);
		push(24'hc0ffee);
		repeat (5) @(posedge mclk);
		rd_reg(`ARC_ADDR_RESULT, 16, 0, 32'hc0ff);
		wr_reg(`ARC_ADDR_IFMODE, 32'h0041, 16, 0);
		rd_reg(`ARC_ADDR_RESULT, 24, 0, 32'hc0ff80);
		wr_reg(`ARC_ADDR_IFMODE, 32'h0040, 16, 0);
		push(24'h010203);
		repeat (5) @(posedge mclk);
		// words arriving mid-read must wait, filling the buffer;
		// the appended status still shows the unread word as ready
		fork
			rd_reg(`ARC_ADDR_RESULT, 32, 0, 32'h01020300);
			begin
				repeat (80) @(posedge mclk);
				push(24'h111111);
				push(24'h222222);
				repeat (3) @(posedge mclk);
				check({31'h0, cr}, 32'h0);
				push(24'h333333);
			end
		join
		repeat (8) @(posedge mclk);
		rd_reg(`ARC_ADDR_RESULT, 32, 0, 32'h33333300);
		wr_reg(`ARC_ADDR_IFMODE, 32'h0004, 16, 0);
		rd_reg(`ARC_ADDR_PINIO, 16, 1, 32'h1234);
		wr_reg(`ARC_ADDR_PINIO, 32'h0a0a, 16, 1);
		rd_reg(`ARC_ADDR_PINIO, 16, 1, 32'h0a0a);
		wr_reg(`ARC_ADDR_IFMODE, 32'h0008, 16, 1);
		rd_reg(`ARC_ADDR_PINIO, 16, 2, 32'h0a0a);
		wr_reg(`ARC_ADDR_PINIO, 32'h5555, 16, 3);
		rd_reg(`ARC_ADDR_PINIO, 16, 2, 32'h0a0a);
		rd_reg(`ARC_ADDR_STATUS, 8, 2, 32'hc0);
		rd_reg(`ARC_ADDR_STATUS, 8, 2, 32'h80);
		// select code 11 behaves as the full crc
		wr_reg(`ARC_ADDR_IFMODE, 32'h000c, 16, 2);
		rd_reg(`ARC_ADDR_PINIO, 16, 2, 32'h0a0a);
		complete_run();
	end
endmodule
